// ---- spi_card_pkg.sv ----
// Constants and types shared by the SPI-mode card protocol engine.
package spi_card_pkg;
    // Command indices supported in SPI mode.
    localparam logic [5:0] CMD_RESET      = 6'h00;
    localparam logic [5:0] CMD_INIT       = 6'h01;
    localparam logic [5:0] CMD_READ_CSD   = 6'h09;
    localparam logic [5:0] CMD_READ_ID    = 6'h0A;
    localparam logic [5:0] CMD_STATUS     = 6'h0D;
    localparam logic [5:0] CMD_SET_LEN    = 6'h10;
    localparam logic [5:0] CMD_READ_BLOCK = 6'h11;
    localparam logic [5:0] CMD_READ_OCR   = 6'h3A;
    localparam logic [5:0] CMD_CRC_OPTION = 6'h3B;

    // Basic response bit positions.
    localparam int R1_IDLE    = 0;
    localparam int R1_ILLEGAL = 2;
    localparam int R1_CRC     = 3;
    localparam int R1_PARAM   = 6;

    // Token bytes.
    localparam logic [7:0] FILL_BYTE   = 8'hFF;
    localparam logic [7:0] START_TOKEN = 8'hFE;
    localparam logic [7:0] ERROR_TOKEN = 8'h01;
    localparam logic [7:0] STATUS_BYTE = 8'h00;
    localparam logic [1:0] START_BITS  = 2'b01;

    // Card geometry and option values.
    localparam logic [9:0]  MAX_READ_BLOCK_LENGTH = 10'h200;
    localparam logic [32:0] CARD_CAPACITY  = 33'h001000000;
    localparam logic [9:0]  REG_BLOCK_BYTES = 10'h010;
    localparam logic [31:0] OCR_VALUE      = 32'h00FF8000;
    localparam logic [1:0]  INIT_POLLS     = 2'h2;
    localparam logic [2:0]  CMD_BYTES      = 3'h6;

    // Polynomials of the command and data checksums.
    localparam logic [6:0]  CRC7_POLY  = 7'h09;
    localparam logic [15:0] CRC16_POLY = 16'h1021;

    // Reply kinds that follow the basic response byte.
    typedef enum logic [1:0] {
        KIND_NONE   = 2'h0,
        KIND_STATUS = 2'h1,
        KIND_OCR    = 2'h2,
        KIND_READ   = 2'h3
    } kind_type;

    // Data sources of a block read.
    typedef enum logic [1:0] {
        SRC_MEM = 2'h0,
        SRC_CSD = 2'h1,
        SRC_ID  = 2'h2
    } source_type;

    // What the transmitter loads at the next byte boundary.
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_GAP    = 4'h1,
        ST_R1     = 4'h3,
        ST_EXTRA  = 4'h2,
        ST_WAIT   = 4'h6,
        ST_DATA   = 4'h7,
        ST_CRC_HI = 4'h5,
        ST_CRC_LO = 4'h4
    } state_type;
endpackage

// ---- crc16_unit.sv ----
// Byte-wise CCITT checksum accumulator for outgoing data blocks.
`timescale 1ns/1ns
module crc16_unit (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        clear,
    input  wire logic        load,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc
);
    import spi_card_pkg::*;

    typedef struct packed {
        logic [15:0] crc;
    } crc_state_type;

    crc_state_type r;
    crc_state_type next_r;

    always_comb begin
        next_r = r;
        if (clear) begin
            next_r.crc = '0;
        end else if (load) begin
            for (int i = 7; i >= 0; i--) begin
                if (next_r.crc[15] ^ data[i]) begin
                    next_r.crc = {next_r.crc[14:0], 1'b0} ^ CRC16_POLY;
                end else begin
                    next_r.crc = {next_r.crc[14:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign crc = r.crc;
endmodule

// ---- card_reg_rom.sv ----
// Card-specific data and identity bytes with a registered read port.
`timescale 1ns/1ns
module card_reg_rom (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [4:0] addr,
    output logic      [7:0] data
);
    import spi_card_pkg::*;

    // Bytes 0-15 hold card-specific data, 16-31 the card identity.
    // The identity bytes are arbitrary neutral values.
    localparam logic [255:0] CONTENTS = {
        128'h00_26_00_32_1F_59_81_C8_BE_FB_CF_FF_92_40_40_01,
        128'h11_22_33_44_55_66_77_88_99_AA_BB_CC_DD_EE_FF_01};

    typedef struct packed {
        logic [7:0] data;
    } rom_state_type;

    rom_state_type r;
    rom_state_type next_r;

    always_comb begin
        next_r      = r;
        next_r.data = CONTENTS[255 - 8 * addr -: 8];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign data = r.data;
endmodule

// ---- spi_card_engine.sv ----
// SPI-mode protocol engine of a read-only memory card.
// Behaviour
// RULE1 - Tokens are whole bytes, counted from chip select assertion.
// RULE2 - Host is sole master and lowers chip select before each command.
// RULE3 - In SPI mode every command gets a response, accept or reject.
// RULE4 - Failed data retrieval sends a one-byte error token, no data; the code sends it only if the first byte of the block fails.
// RULE5 - Only single-block reads, one byte up to one sector.
// RULE6 - Reset command with chip select low enters SPI mode and responds.
// RULE7 - Reset command with chip select high gives no response.
// RULE8 - SPI mode is left only by power cycle.
// RULE9 - No native state machine; supported commands accepted anytime.
// RULE10 - With protection off, checksum fields are carried but ignored.
// RULE11 - Checking starts off; entry reset needs a valid checksum.
// RULE12 - The checksum option command turns checking on or off.
// RULE13 - Block read returns response then one token of set length.
// RULE14 - Each valid data block carries a 16-bit CCITT checksum.
// RULE15 - Length limited by maximum; partial flag allows 1 to maximum.
// RULE16 - Any byte address in range may start a block read.
// RULE17 - Identity and card data reads are 16-byte block reads.
// RULE18 - Register read latency follows command-response count.
// RULE19 - After reset, idle state allows only init and OPERATING_CONDITIONS_REGISTER read; the code also accepts reset.
// RULE20 - Host repeats init until the idle bit reads zero.
// RULE21 - Init takes no operand; OPERATING_CONDITIONS_REGISTER read returns register any time.
// RULE22 - Reject unsupported opcode, bad checksum or illegal operand.
// RULE23 - Commands are six bytes: 0,1, index, argument, checksum, 1.
// RULE24 - Basic response is one byte with a zero top bit.
// RULE25 - Host keeps chip select low for the whole transaction.
`timescale 1ns/1ns
module spi_card_engine (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    input  wire logic        partial_read_allowed,
    output logic             mem_req,
    output logic      [23:0] mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [7:0]  mem_data,
    input  wire logic        mem_error,
    output logic             spi_mode,
    output logic             crc_enabled,
    output logic             in_idle
);
    import spi_card_pkg::*;

    typedef struct packed {
        logic        sclk_s1;
        logic        sclk_s2;
        logic        sclk_s3;
        logic        cs_s1;
        logic        cs_s2;
        logic        mosi_s1;
        logic        mosi_s2;
        logic [2:0]  bit_cnt;
        logic [7:0]  rx_byte;
        logic [39:0] cmd_buf;
        logic [2:0]  cmd_cnt;
        logic [7:0]  tx_shift;
        state_type   state;
        logic        spi_mode;
        logic        crc_on;
        logic        idle;
        logic [1:0]  polls;
        logic [9:0]  block_len;
        logic [7:0]  resp;
        kind_type    kind;
        logic [1:0]  extra_cnt;
        source_type  src;
        logic [9:0]  remain;
        logic [23:0] addr;
        logic        req;
        logic        rom_ack;
        logic [7:0]  prefetch;
        logic        pf_valid;
        logic        pf_error;
    } engine_state_type;

    engine_state_type r;
    engine_state_type next_r;

    logic        crc_clear;
    logic        crc_load;
    logic [15:0] crc16;
    logic [7:0]  rom_data;
    logic [7:0]  full;
    logic [47:0] cmd;
    logic [5:0]  idx;
    logic [31:0] arg;
    logic        crc_ok;
    logic        sclk_rise;
    logic        sclk_fall;

    function automatic logic [6:0] crc7_of(input logic [39:0] d);
        logic [6:0] c;
        c = '0;
        for (int i = 39; i >= 0; i--) begin
            c = {c[5:0], 1'b0} ^ ((c[6] ^ d[i]) ? CRC7_POLY : 7'h00);
        end
        return c;
    endfunction

    crc16_unit data_crc (
        .clk    (clk),
        .resetn (resetn),
        .clear  (crc_clear),
        .load   (crc_load),
        .data   (r.prefetch),
        .crc    (crc16)
    );

    card_reg_rom reg_rom (
        .clk    (clk),
        .resetn (resetn),
        .addr   ({r.src == SRC_ID, r.addr[3:0]}),
        .data   (rom_data)
    );

    assign sclk_rise = r.sclk_s2 & ~r.sclk_s3;
    assign sclk_fall = ~r.sclk_s2 & r.sclk_s3;
    assign full      = {r.rx_byte[6:0], r.mosi_s2};
    assign cmd       = {r.cmd_buf, full};
    assign idx       = cmd[45:40];
    assign arg       = cmd[39:8];
    assign crc_ok    = (crc7_of(cmd[47:8]) == cmd[7:1]) && cmd[0];

    always_comb begin
        next_r         = r;
        crc_clear      = 1'b0;
        crc_load       = 1'b0;
        next_r.sclk_s1 = spi_sclk;
        next_r.sclk_s2 = r.sclk_s1;
        next_r.sclk_s3 = r.sclk_s2;
        next_r.cs_s1   = spi_cs_n;
        next_r.cs_s2   = r.cs_s1;
        next_r.mosi_s1 = spi_mosi;
        next_r.mosi_s2 = r.mosi_s1;
        next_r.req     = 1'b0;
        next_r.rom_ack = r.req && (r.src != SRC_MEM);

        // Fetched byte lands in the prefetch register.
        if ((r.src == SRC_MEM && mem_ack && !r.req) || r.rom_ack) begin
            next_r.prefetch = (r.src == SRC_MEM) ? mem_data : rom_data;
            next_r.pf_error = (r.src == SRC_MEM) && mem_error;
            next_r.pf_valid = 1'b1;
        end

        if (r.cs_s2) begin // RULE7
            // Deselect realigns bytes and abandons any reply.
            next_r.bit_cnt  = '0;
            next_r.cmd_cnt  = '0;
            next_r.tx_shift = FILL_BYTE;
            next_r.state    = ST_IDLE; // RULE25
        end else if (sclk_rise) begin
            next_r.rx_byte = full;
            next_r.bit_cnt = r.bit_cnt + 3'h1; // RULE1
            if (r.bit_cnt == 3'h7 && r.state == ST_IDLE) begin
                if (r.cmd_cnt == '0 && full[7:6] != START_BITS) begin
                    next_r.cmd_cnt = '0; // RULE23
                end else if (r.cmd_cnt != CMD_BYTES - 3'h1) begin
                    next_r.cmd_buf = {r.cmd_buf[31:0], full};
                    next_r.cmd_cnt = r.cmd_cnt + 3'h1;
                end else begin
                    next_r.cmd_cnt = '0;
                    next_r.kind    = KIND_NONE;
                    if (!r.spi_mode) begin
                        // The entry reset must carry a valid checksum.
                        if (idx == CMD_RESET && crc_ok) begin // RULE11
                            next_r.spi_mode = 1'b1; // RULE6 RULE8
                            next_r.crc_on   = 1'b0;
                            next_r.idle     = 1'b1;
                            next_r.polls    = '0;
                            next_r.resp     = 8'h01;
                            next_r.state    = ST_GAP;
                        end
                    end else begin
                        next_r.resp  = '0; // RULE24
                        next_r.state = ST_GAP; // RULE3
                        if (r.crc_on && !crc_ok) begin // RULE10
                            next_r.resp[R1_CRC] = 1'b1; // RULE22
                        end else if (r.idle && idx != CMD_RESET &&
                                     idx != CMD_INIT &&
                                     idx != CMD_READ_OCR) begin
                            next_r.resp[R1_ILLEGAL] = 1'b1; // RULE19
                        end else begin
                            case (idx) // RULE9
                                CMD_RESET: begin
                                    next_r.idle  = 1'b1; // RULE19
                                    next_r.polls = '0;
                                end
                                CMD_INIT: begin
                                    // Operand is ignored.
                                    if (r.polls == INIT_POLLS - 2'h1) begin
                                        next_r.idle = 1'b0; // RULE21
                                    end else begin
                                        next_r.polls = r.polls + 2'h1;
                                    end
                                end
                                CMD_READ_OCR: next_r.kind = KIND_OCR; // RULE21
                                CMD_STATUS: next_r.kind = KIND_STATUS;
                                CMD_CRC_OPTION: begin
                                    next_r.crc_on = arg[0]; // RULE12
                                end
                                CMD_SET_LEN: begin
                                    if (arg == '0 ||
                                        arg > 32'(MAX_READ_BLOCK_LENGTH) ||
                                        (!partial_read_allowed &&
                                         arg != 32'(MAX_READ_BLOCK_LENGTH)))
                                    begin
                                        next_r.resp[R1_PARAM] = 1'b1; // RULE15
                                    end else begin
                                        next_r.block_len = arg[9:0];
                                    end
                                end
                                CMD_READ_BLOCK: begin
                                    if ({1'b0, arg} + 33'(r.block_len) >
                                        CARD_CAPACITY) begin
                                        next_r.resp[R1_PARAM] = 1'b1; // RULE16
                                    end else begin
                                        next_r.kind   = KIND_READ; // RULE5
                                        next_r.src    = SRC_MEM;
                                        next_r.addr   = arg[23:0];
                                        next_r.remain = r.block_len; // RULE13
                                    end
                                end
                                CMD_READ_CSD, CMD_READ_ID: begin
                                    next_r.kind   = KIND_READ; // RULE17
                                    next_r.src    = (idx == CMD_READ_ID) ?
                                                    SRC_ID : SRC_CSD;
                                    next_r.addr   = '0;
                                    next_r.remain = REG_BLOCK_BYTES;
                                end
                                default: begin
                                    next_r.resp[R1_ILLEGAL] = 1'b1; // RULE22
                                end
                            endcase
                        end
                        next_r.resp[R1_IDLE] = next_r.idle;
                    end
                end
            end
        end else if (sclk_fall) begin
            if (r.bit_cnt != '0) begin
                next_r.tx_shift = {r.tx_shift[6:0], 1'b1};
            end else begin
                // Byte boundary: choose the next byte to send.
                next_r.tx_shift = FILL_BYTE;
                case (r.state)
                    ST_GAP: begin
                        next_r.state = ST_R1;
                    end
                    ST_R1: begin
                        next_r.tx_shift  = r.resp; // RULE24
                        next_r.extra_cnt = '0;
                        next_r.pf_valid  = 1'b0;
                        case (r.kind)
                            KIND_STATUS, KIND_OCR: next_r.state = ST_EXTRA;
                            KIND_READ: begin
                                // Register reads answer within a byte.
                                next_r.req   = 1'b1; // RULE18
                                next_r.state = ST_WAIT;
                            end
                            default: next_r.state = ST_IDLE;
                        endcase
                    end
                    ST_EXTRA: begin
                        next_r.extra_cnt = r.extra_cnt + 2'h1;
                        if (r.kind == KIND_STATUS) begin
                            next_r.tx_shift = STATUS_BYTE;
                            next_r.state    = ST_IDLE;
                        end else begin
                            next_r.tx_shift =
                                OCR_VALUE[31 - 8 * r.extra_cnt -: 8];
                            if (r.extra_cnt == 2'h3) begin
                                next_r.state = ST_IDLE;
                            end
                        end
                    end
                    ST_WAIT: begin
                        if (r.pf_valid && r.pf_error) begin
                            next_r.tx_shift = ERROR_TOKEN; // RULE4
                            next_r.state    = ST_IDLE;
                        end else if (r.pf_valid) begin
                            next_r.tx_shift = START_TOKEN;
                            crc_clear       = 1'b1;
                            next_r.state    = ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        // Memory must refill the prefetch within a byte.
                        next_r.tx_shift = r.prefetch;
                        crc_load        = 1'b1; // RULE14
                        next_r.pf_valid = 1'b0;
                        next_r.addr     = r.addr + 24'h1;
                        next_r.remain   = r.remain - 10'h1;
                        if (r.remain == 10'h1) begin
                            next_r.state = ST_CRC_HI;
                        end else begin
                            next_r.req = 1'b1;
                        end
                    end
                    ST_CRC_HI: begin
                        next_r.tx_shift = crc16[15:8]; // RULE14
                        next_r.state    = ST_CRC_LO;
                    end
                    ST_CRC_LO: begin
                        next_r.tx_shift = crc16[7:0];
                        next_r.state    = ST_IDLE;
                    end
                    default: begin
                        next_r.state = ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r           <= '0;
            r.cs_s1     <= 1'b1;
            r.cs_s2     <= 1'b1;
            r.tx_shift  <= FILL_BYTE;
            r.idle      <= 1'b1;
            r.block_len <= MAX_READ_BLOCK_LENGTH;
        end else begin
            r <= next_r;
        end
    end

    assign spi_miso    = r.tx_shift[7];
    assign mem_req     = r.req && (r.src == SRC_MEM);
    assign mem_addr    = r.addr;
    assign spi_mode    = r.spi_mode;
    assign crc_enabled = r.crc_on;
    assign in_idle     = r.idle;
endmodule

// ---- spi_card_engine_checker.sv ----
// Temporal checks on the ports of the SPI-mode card engine.
`timescale 1ns/1ns
module spi_card_engine_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_miso,
    input wire logic mem_req,
    input wire logic spi_mode,
    input wire logic crc_enabled,
    input wire logic in_idle
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_desel;
        spi_cs_n [*8];
    endsequence
    sequence s_sclk_high;
        (spi_sclk && !spi_cs_n) [*6];
    endsequence
    property p_reset_vals;
        disable iff (1'b0) !resetn |=> !spi_mode && !crc_enabled
            && in_idle && spi_miso && !mem_req;
    endproperty
    property p_mode_kept;
        spi_mode |=> spi_mode;
    endproperty
    property p_no_mode_unsel;
        !spi_mode ##0 s_desel |=> !spi_mode;
    endproperty
    property p_desel_quiet;
        s_desel |-> spi_miso;
    endproperty
    // A bit may only move after a falling edge, so a long high phase holds it.
    property p_miso_hold;
        s_sclk_high |=> $stable(spi_miso);
    endproperty
    property p_req_pulse;
        mem_req |=> !mem_req;
    endproperty
    property p_req_ready;
        mem_req |-> spi_mode && !in_idle;
    endproperty
    property p_crc_in_mode;
        crc_enabled |-> spi_mode;
    endproperty
    property p_idle_fall;
        $fell(in_idle) |-> spi_mode;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");
    a_mode_kept: assert property (p_mode_kept)
        else $error("spi mode left");
    a_no_mode_unsel: assert property (p_no_mode_unsel)
        else $error("mode entered while deselected");
    a_desel_quiet: assert property (p_desel_quiet)
        else $error("data out driven while deselected");
    a_miso_hold: assert property (p_miso_hold)
        else $error("data out moved in high phase");
    a_req_pulse: assert property (p_req_pulse)
        else $error("memory request too long");
    a_req_ready: assert property (p_req_ready)
        else $error("memory read before init");
    a_crc_in_mode: assert property (p_crc_in_mode)
        else $error("checking on outside spi mode");
    a_idle_fall: assert property (p_idle_fall)
        else $error("idle cleared outside spi mode");
endmodule
bind spi_card_engine spi_card_engine_checker chk_i (.clk(clk),
    .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_miso(spi_miso), .mem_req(mem_req), .spi_mode(spi_mode),
    .crc_enabled(crc_enabled), .in_idle(in_idle));

// ---- card_mem_model.sv ----
// Byte memory behind the card, answering promptly or slowly.
`timescale 1ns/1ns
module card_mem_model #(
    parameter logic [23:0] BAD_ADDR = 24'h000777
) (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic [23:0] mem_addr,
    output logic             mem_ack,
    output logic      [7:0]  mem_data,
    output logic             mem_error
);
    logic [5:0]  wait_cnt = 6'h00;
    logic [23:0] addr     = 24'h000000;
    initial {mem_ack, mem_data, mem_error} = 10'h000;
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        mem_data <= ~mem_data; // Stale data never looks steady.
        if (mem_req) begin
            addr <= mem_addr;
            wait_cnt <= slow ? 6'h28 : 6'h01;
        end else if (wait_cnt != 6'h00) begin
            wait_cnt <= wait_cnt - 6'h01;
            if (wait_cnt == 6'h01) begin
                mem_ack <= 1'b1;
                mem_data <= addr[7:0] ^ 8'hA5;
                mem_error <= (addr == BAD_ADDR);
            end
        end
    end
endmodule

// ---- tb.sv ----
// Self-checking bench driving the card engine as an SPI host.
`timescale 1ns/1ns
module tb;
    import spi_card_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, cs_n = 1'b1, sclk = 1'b0, mosi = 1'b1;
    logic miso, part = 1'b0, slow = 1'b0, desel = 1'b0;
    logic req, ack, mdat_err, mode, crc_on, idle;
    logic [23:0] maddr;
    logic [7:0]  mdat, r;
    int error_cnt = 0, checks_done = 0, cycles = 0;
    spi_card_engine dut (.clk(clk), .resetn(resetn), .spi_cs_n(cs_n),
        .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
        .partial_read_allowed(part), .mem_req(req), .mem_addr(maddr),
        .mem_ack(ack), .mem_data(mdat), .mem_error(mdat_err),
        .spi_mode(mode), .crc_enabled(crc_on), .in_idle(idle));
    card_mem_model mem (.clk(clk), .slow(slow), .mem_req(req),
        .mem_addr(maddr), .mem_ack(ack), .mem_data(mdat),
        .mem_error(mdat_err));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [6:0] crc7(input logic [39:0] f);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 39; i >= 0; i--)
            c = {c[5:0], 1'b0} ^ ((c[6] ^ f[i]) ? 7'h09 : 7'h00);
        return c;
    endfunction
    function automatic logic [15:0] crc16(input logic [15:0] c,
                                          input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    // Host samples on the rising edge; each phase lasts eight clocks.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            tick(8);
            sclk = 1'b1;
            rx[i] = miso;
            tick(8);
            sclk = 1'b0;
        end
    endtask
    // Each command starts with a deselect, which ends any reply, then selects unless desel is set.
    task automatic cmd(input logic [5:0] idx, input logic [31:0] arg,
                       input logic bad, input logic [7:0] exp);
        logic [39:0] f;
        f = {2'b01, idx, arg};
        cs_n = 1'b1;
        tick(24);
        cs_n = desel;
        tick(8);
        for (int i = 4; i >= 0; i--) xfer(f[i*8+:8], r);
        xfer({crc7(f) ^ {bad, 6'h00}, 1'b1}, r);
        xfer(8'hFF, r);
        xfer(8'hFF, r);
        chk8(r, exp);
    endtask
    task automatic blk(input int n, input logic [23:0] a,
                       input logic [7:0] tok);
        logic [7:0]  h;
        logic [15:0] c;
        c = 16'h0000;
        r = 8'hFF;
        for (int i = 0; i < 40 && r === 8'hFF; i++) xfer(8'hFF, r);
        chk8(r, tok);
        if (tok == START_TOKEN) begin
            for (int i = 0; i < n; i++) begin
                xfer(8'hFF, r);
                c = crc16(c, r);
                if (n != 16) chk8(r, (a[7:0] + 8'(i)) ^ 8'hA5);
            end
            xfer(8'hFF, r);
            xfer(8'hFF, h);
            chk16({r, h}, c);
        end
    endtask
    initial begin
        tick(16);
        resetn = 1'b1;
        tick(8);
        desel = 1'b1;
        cmd(CMD_RESET, 32'h0, 1'b0, 8'hFF);
        chk8(8'(mode), 8'h00);
        desel = 1'b0;
        cmd(CMD_RESET, 32'h0, 1'b1, 8'hFF);
        cmd(CMD_RESET, 32'h0, 1'b0, 8'h01);
        cmd(CMD_READ_BLOCK, 32'h0, 1'b0, 8'h05);
        cmd(CMD_READ_OCR, 32'h0, 1'b0, 8'h01);
        for (int i = 3; i >= 0; i--) begin
            xfer(8'hFF, r);
            chk8(r, OCR_VALUE[i*8+:8]);
        end
        cmd(CMD_INIT, 32'h0, 1'b0, 8'h01);
        cmd(CMD_INIT, 32'h0, 1'b0, 8'h00);
        chk8(8'(idle), 8'h00);
        cmd(CMD_STATUS, 32'h0, 1'b0, 8'h00);
        xfer(8'hFF, r);
        chk8(r, 8'h00);
        cmd(6'h02, 32'h0, 1'b0, 8'h04);
        cmd(CMD_SET_LEN, 32'h0, 1'b0, 8'h40);
        cmd(CMD_SET_LEN, 32'h4, 1'b0, 8'h40);
        cmd(CMD_READ_CSD, 32'h0, 1'b0, 8'h00);
        blk(16, 24'h0, START_TOKEN);
        cmd(CMD_READ_ID, 32'h0, 1'b0, 8'h00);
        blk(16, 24'h0, START_TOKEN);
        part = 1'b1;
        cmd(CMD_SET_LEN, 32'h4, 1'b0, 8'h00);
        cmd(CMD_READ_BLOCK, 32'hFE, 1'b0, 8'h00);
        blk(4, 24'hFE, START_TOKEN);
        slow = 1'b1;
        cmd(CMD_READ_BLOCK, 32'h123456, 1'b0, 8'h00);
        blk(4, 24'h123456, START_TOKEN);
        slow = 1'b0;
        cmd(CMD_READ_BLOCK, 32'h777, 1'b0, 8'h00);
        blk(4, 24'h777, ERROR_TOKEN);
        cmd(CMD_READ_BLOCK, 32'hFFFFFE, 1'b0, 8'h40);
        cmd(CMD_SET_LEN, 32'h1, 1'b0, 8'h00);
        cmd(CMD_READ_BLOCK, 32'hFFFFFF, 1'b0, 8'h00);
        blk(1, 24'hFFFFFF, START_TOKEN);
        cmd(CMD_READ_OCR, 32'h0, 1'b1, 8'h00);
        cmd(CMD_CRC_OPTION, 32'h1, 1'b0, 8'h00);
        chk8(8'(crc_on), 8'h01);
        cmd(CMD_READ_OCR, 32'h0, 1'b1, 8'h08);
        cmd(CMD_CRC_OPTION, 32'h0, 1'b0, 8'h00);
        chk8(8'(crc_on), 8'h00);
        cmd(CMD_RESET, 32'h0, 1'b0, 8'h01);
        chk8(8'(mode), 8'h01);
        wrap_up();
    end
endmodule
